// >>> design/fsp_protect.sv
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "fsp_regs.svh"
module fsp_protect
   import fsp_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RSTN,
   // Nonvolatile bytes: option and protect bytes sampled while reset is low, key bytes used live
   input  wire logic [7:0]  NV_OPTION_BYTE,
   input  wire logic [7:0]  NV_PROTECT_BYTE,
   input  wire logic [63:0] BACKDOOR_KEY_BYTES,
   // Register port
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic        REG_FROM_DEBUG,
   output logic [7:0]       REG_RDATA,
   // Flash array write path
   input  wire logic [15:0] MEM_WR_ADDR,
   input  wire logic [7:0]  MEM_WR_DATA,
   input  wire logic        MEM_WR,
   input  wire logic        MEM_FROM_SECURE,
   output logic             CMD_START,
   output logic [15:0]      CMD_ADDR,
   // Command launch check
   input  wire logic        CMD_LAUNCH,
   input  wire logic [15:0] CMD_TARGET,
   input  wire logic        BLANK_CHECK_OK,
   output logic             CMD_ACCEPT,
   // Memory access gating
   input  wire logic        ACCESS_REQ,
   input  wire logic        ACCESS_SECURE_SRC,
   output logic             ACCESS_GRANT,
   // Status
   output logic             SECURE,
   output logic             VECTOR_REDIRECT_EN,
   output logic             PROTECTION_VIOLATION_FLAG
);
   logic [7:0]  option_shadow_register_r;
   logic [7:0]  configuration_register_r;
   logic [7:0]  protection_shadow_register_r;
   logic [1:0]  security_field_r;
   logic        violation_r;
   logic        key_ok_r;
   logic [7:0]  rdata_r;
   logic        cmd_start_r;
   logic [15:0] cmd_addr_r;
   logic        cmd_accept_r;
   logic        grant_r;
   logic        in_reset_r;
   fsp_key_state_type key_state_r;

   logic        backdoor_enable;
   logic        key_access;
   logic        protection_disable;
   logic        in_key_range;
   logic        key_write;
   logic        key_access_clear;
   logic        key_all_seen;
   logic        key_match;
   logic        launch_protected;
   logic        wr_cfg;
   logic        wr_prot;
   logic        wr_stat;
   logic [2:0]  key_index;

   // Protected region: everything above the unprotected end address
   function automatic logic is_protected(input logic [7:0]  prot,
                                         input logic [15:0] addr);
      logic [15:0] unprot_end;
      unprot_end = 16'({prot[7:1], 9'h1FF});
      if (prot[`FSP_PROT_DIS_BIT])
         is_protected = 1'b0;
      else
         is_protected = addr > unprot_end;
   endfunction

   function automatic logic sec_is_secure(input logic [1:0] sec);
      sec_is_secure = (sec != `FSP_SEC_UNSECURED);
   endfunction

   assign backdoor_enable    =
      option_shadow_register_r[`FSP_OPT_BACKDOOR_BIT];
   assign key_access         =
      configuration_register_r[`FSP_CFG_KEY_ACCESS_BIT];
   assign protection_disable =
      protection_shadow_register_r[`FSP_PROT_DIS_BIT];
   assign in_key_range = (MEM_WR_ADDR >= `FSP_KEY_BASE)
      && (MEM_WR_ADDR < `FSP_KEY_BASE + 16'(`FSP_KEY_BYTES));
   assign key_index = MEM_WR_ADDR[2:0];
   assign key_write = MEM_WR && in_key_range && key_access
      && MEM_FROM_SECURE && backdoor_enable;
   assign wr_cfg  = REG_WR && (REG_ADDR == `FSP_ADDR_CFG);
   assign wr_prot = REG_WR && (REG_ADDR == `FSP_ADDR_PROT);
   assign wr_stat = REG_WR && (REG_ADDR == `FSP_ADDR_STAT);
   assign key_access_clear = wr_cfg && key_access
      && !REG_WDATA[`FSP_CFG_KEY_ACCESS_BIT];
   assign launch_protected =
      is_protected(protection_shadow_register_r, CMD_TARGET);

   fsp_key_compare u_key_compare (
      .CLK        (CLK),
      .RSTN       (RSTN),
      .clear      (key_access_clear),
      .byte_valid (key_write),
      .byte_index (key_index),
      .byte_data  (MEM_WR_DATA),
      .stored_key (BACKDOOR_KEY_BYTES),
      .all_seen   (key_all_seen),
      .match      (key_match)
   );

   // Shadow loads happen while reset is held, sampled on the clock
   always_ff @(posedge CLK) begin
      in_reset_r <= !RSTN;
      if (!RSTN) begin
         option_shadow_register_r <=
            NV_OPTION_BYTE & `FSP_OPT_USED_MASK;
      end
      // Otherwise no write path exists
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         configuration_register_r <= 8'h00;
      end else if (wr_cfg) begin
         configuration_register_r <= REG_WDATA & `FSP_CFG_MASK;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         protection_shadow_register_r <= NV_PROTECT_BYTE;
      end else if (wr_prot && REG_FROM_DEBUG && !protection_disable
                   && REG_WDATA[7:1]
                      < protection_shadow_register_r[7:1]) begin
         // Only growth of the protected block; disable bit freezes it
         protection_shadow_register_r <=
            {REG_WDATA[7:1], 1'b0};
      end
   end

   // Security field: reset value from option byte, unlocks stick to reset
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         security_field_r <= NV_OPTION_BYTE[1:0];
         key_state_r      <= FSP_KEY_IDLE;
      end else begin
         case (key_state_r)
            FSP_KEY_IDLE: begin
               if (key_write)
                  key_state_r <= FSP_KEY_FILL;
            end
            FSP_KEY_FILL: begin
               if (key_access_clear) begin
                  key_state_r <= FSP_KEY_DONE;
               end
            end
            FSP_KEY_DONE: begin
               key_state_r <= FSP_KEY_IDLE;
            end
            default: key_state_r <= FSP_KEY_IDLE;
         endcase
         if (key_access_clear && key_state_r == FSP_KEY_FILL
             && backdoor_enable && key_all_seen && key_match)
            security_field_r <= `FSP_SEC_UNSECURED;
         else if (BLANK_CHECK_OK)
            security_field_r <= `FSP_SEC_UNSECURED;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         key_ok_r <= 1'b0;
      end else if (key_access_clear && key_state_r == FSP_KEY_FILL
                   && backdoor_enable && key_all_seen && key_match) begin
         key_ok_r <= 1'b1;
      end else if (wr_stat && REG_WDATA[`FSP_STAT_KEYOK_BIT]) begin
         key_ok_r <= 1'b0;
      end
   end

   // Set wins over a simultaneous write-one clear
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         violation_r <= 1'b0;
      end else if (CMD_LAUNCH && launch_protected) begin
         violation_r <= 1'b1;
      end else if (wr_stat && REG_WDATA[`FSP_STAT_VIOL_BIT]) begin
         violation_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         cmd_accept_r <= 1'b0;
      end else begin
         cmd_accept_r <= CMD_LAUNCH && !launch_protected;
      end
   end

   // Key-range writes start commands only while key access is clear
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         cmd_start_r <= 1'b0;
         cmd_addr_r  <= 16'h0000;
      end else begin
         cmd_start_r <= MEM_WR && !(in_key_range && key_access);
         if (MEM_WR)
            cmd_addr_r <= MEM_WR_ADDR;
      end
   end

   // Key writes from debug are silently dropped
   // (key_write requires MEM_FROM_SECURE)

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         grant_r <= 1'b0;
      end else begin
         grant_r <= ACCESS_REQ && (ACCESS_SECURE_SRC
            || !sec_is_secure(security_field_r));
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         rdata_r <= 8'h00;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `FSP_ADDR_OPT:
               rdata_r <= {option_shadow_register_r[7:6], 4'h0,
                           security_field_r};
            `FSP_ADDR_CFG:  rdata_r <= configuration_register_r;
            `FSP_ADDR_PROT: rdata_r <= protection_shadow_register_r;
            `FSP_ADDR_STAT: rdata_r <= {6'h00, key_ok_r, violation_r};
            default:        rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign REG_RDATA          = rdata_r;
   assign CMD_START          = cmd_start_r;
   assign CMD_ADDR           = cmd_addr_r;
   assign CMD_ACCEPT         = cmd_accept_r;
   assign ACCESS_GRANT       = grant_r;
   assign SECURE             = sec_is_secure(security_field_r) || in_reset_r;
   assign VECTOR_REDIRECT_EN =
      !option_shadow_register_r[`FSP_OPT_NORED_BIT];
   assign PROTECTION_VIOLATION_FLAG = violation_r;
endmodule // fsp_protect

// >>> pkg/fsp_regs.svh
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// Register offsets (byte addresses on the plain register port)
`define FSP_ADDR_OPT       4'h0
`define FSP_ADDR_CFG       4'h1
`define FSP_ADDR_PROT      4'h2
`define FSP_ADDR_STAT      4'h3

// Option register fields
`define FSP_OPT_BACKDOOR_BIT 7
`define FSP_OPT_NORED_BIT  6
`define FSP_OPT_USED_MASK  8'hC3
`define FSP_SEC_UNSECURED  2'h2

// Configuration register fields
`define FSP_CFG_MASK       8'hE0
`define FSP_CFG_KEY_ACCESS_BIT 5

// Protection register fields
`define FSP_PROT_DIS_BIT   0

// Status register fields (clear by writing one)
`define FSP_STAT_VIOL_BIT  0
`define FSP_STAT_KEYOK_BIT 1

// Backdoor key window
`define FSP_KEY_BASE       16'hFFB0
`define FSP_KEY_BYTES      4'h8
`define FSP_KEY_LAST       3'h7

// Flash array geometry: protect_select scales by 512-byte blocks
`define FSP_BLOCK_SHIFT    9
`define FSP_FLASH_TOP      16'hFFFF

`endif

// >>> pkg/fsp_pkg.sv
package fsp_pkg;
   typedef enum logic [1:0] {
      FSP_KEY_IDLE,
      FSP_KEY_FILL,
      FSP_KEY_DONE
   } fsp_key_state_type;
endpackage

// >>> design/fsp_key_compare.sv
`timescale 1ns/1ns
`include "fsp_regs.svh"
module fsp_key_compare
   import fsp_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RSTN,
   // Byte stream
   input  wire logic        clear,
   input  wire logic        byte_valid,
   input  wire logic [2:0]  byte_index,
   input  wire logic [7:0]  byte_data,
   input  wire logic [63:0] stored_key,
   // Result
   output logic             all_seen,
   output logic             match
);
   logic [7:0] seen_r;
   logic       match_r;

   function automatic logic [7:0] key_byte(input logic [63:0] k,
                                           input logic [2:0]  i);
      key_byte = k[{i, 3'h0} +: 8];
   endfunction

   // Each byte must arrive at its own ascending slot
   always_ff @(posedge CLK) begin
      if (!RSTN || clear) begin
         seen_r  <= 8'h00;
         match_r <= 1'b1;
      end else if (byte_valid) begin
         seen_r[byte_index] <= 1'b1;
         if (byte_data != key_byte(stored_key, byte_index)
             || (byte_index != 3'h0 && !seen_r[byte_index - 3'h1]))
            match_r <= 1'b0;
      end
   end

   assign all_seen = &seen_r;
   assign match    = match_r & all_seen;
endmodule // fsp_key_compare

// >>> sim/fsp_protect_assertions.sv
`timescale 1ns/1ns
`include "fsp_regs.svh"
module fsp_protect_checker (
   // Clock, reset, nonvolatile option byte
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic [7:0]  NV_OPTION_BYTE,
   // Register port and flash write path
   input wire logic [3:0]  REG_ADDR,
   input wire logic [7:0]  REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [7:0]  REG_RDATA,
   input wire logic [15:0] MEM_WR_ADDR,
   input wire logic        MEM_WR,
   input wire logic        CMD_START,
   input wire logic [15:0] CMD_ADDR,
   // Command check, access gating, status
   input wire logic        CMD_LAUNCH,
   input wire logic        CMD_ACCEPT,
   input wire logic        ACCESS_REQ,
   input wire logic        ACCESS_SECURE_SRC,
   input wire logic        ACCESS_GRANT,
   input wire logic        SECURE,
   input wire logic        VECTOR_REDIRECT_EN,
   input wire logic        PROTECTION_VIOLATION_FLAG
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   opt_gap_zero_a: assert property (
      REG_RD && REG_ADDR == `FSP_ADDR_OPT |=> REG_RDATA[5:2] == 4'h0)
      else $error("option bits 5:2 not zero");
   cfg_low_zero_a: assert property (
      REG_RD && REG_ADDR == `FSP_ADDR_CFG |=> REG_RDATA[4:0] == 5'h00)
      else $error("config bits 4:0 not zero");
   redirect_load_a: assert property (
      $rose(RSTN) |-> VECTOR_REDIRECT_EN == !$past(NV_OPTION_BYTE[6]))
      else $error("vector redirect does not follow option bit 6");
   rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 8'h00)
      else $error("read data outside read answer cycle");
   cmd_route_a: assert property (
      MEM_WR && MEM_WR_ADDR[15:3] != 13'h1FF6
      |=> CMD_START && CMD_ADDR == $past(MEM_WR_ADDR))
      else $error("flash write outside key range did not start command");
   start_cause_a: assert property (CMD_START |-> $past(MEM_WR))
      else $error("command start without flash write");
   accept_cause_a: assert property (CMD_ACCEPT |-> $past(CMD_LAUNCH))
      else $error("command accepted without launch");
   launch_result_a: assert property (
      CMD_LAUNCH |=> CMD_ACCEPT || PROTECTION_VIOLATION_FLAG)
      else $error("launch neither accepted nor flagged");
   viol_sticky_a: assert property (
      PROTECTION_VIOLATION_FLAG
      && !(REG_WR && REG_ADDR == `FSP_ADDR_STAT && REG_WDATA[0])
      |=> PROTECTION_VIOLATION_FLAG)
      else $error("violation flag dropped without clear");
   grant_block_a: assert property (
      ACCESS_REQ && !ACCESS_SECURE_SRC && SECURE |=> !ACCESS_GRANT)
      else $error("access granted to unsecured source while secure");
endmodule // fsp_protect_checker

bind fsp_protect fsp_protect_checker u_chk (
   .CLK(CLK), .RSTN(RSTN), .NV_OPTION_BYTE(NV_OPTION_BYTE),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_WR_ADDR(MEM_WR_ADDR),
   .MEM_WR(MEM_WR), .CMD_START(CMD_START), .CMD_ADDR(CMD_ADDR),
   .CMD_LAUNCH(CMD_LAUNCH), .CMD_ACCEPT(CMD_ACCEPT),
   .ACCESS_REQ(ACCESS_REQ), .ACCESS_SECURE_SRC(ACCESS_SECURE_SRC),
   .ACCESS_GRANT(ACCESS_GRANT), .SECURE(SECURE),
   .VECTOR_REDIRECT_EN(VECTOR_REDIRECT_EN),
   .PROTECTION_VIOLATION_FLAG(PROTECTION_VIOLATION_FLAG)
);

// >>> sim/testbench.sv
`timescale 1ns/1ns
`include "fsp_regs.svh"
module testbench;
   logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, dbg = 1'b0;
   logic        mwr = 1'b0, msec = 1'b1, launch = 1'b0, blank = 1'b0;
   logic        areq = 1'b0, asec = 1'b0, cstart, accept, grant;
   logic        secure, redir, viol;
   logic [7:0]  nv_opt = 8'h00, nv_prot = 8'hFE, wdata = 8'h00;
   logic [7:0]  mdata = 8'h00, rdata;
   logic [3:0]  addr = 4'h0;
   logic [15:0] maddr = 16'h0000, target = 16'h0000, caddr;
   logic [63:0] key = 64'h8877665544332211;
   int          miscompares = 0, n_compared = 0;

   always #4 clk = ~clk;

   fsp_protect u_dut (
      .CLK(clk), .RSTN(rstn), .NV_OPTION_BYTE(nv_opt),
      .NV_PROTECT_BYTE(nv_prot), .BACKDOOR_KEY_BYTES(key),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
      .REG_FROM_DEBUG(dbg), .REG_RDATA(rdata), .MEM_WR_ADDR(maddr),
      .MEM_WR_DATA(mdata), .MEM_WR(mwr), .MEM_FROM_SECURE(msec),
      .CMD_START(cstart), .CMD_ADDR(caddr), .CMD_LAUNCH(launch),
      .CMD_TARGET(target), .BLANK_CHECK_OK(blank), .CMD_ACCEPT(accept),
      .ACCESS_REQ(areq), .ACCESS_SECURE_SRC(asec), .ACCESS_GRANT(grant),
      .SECURE(secure), .VECTOR_REDIRECT_EN(redir),
      .PROTECTION_VIOLATION_FLAG(viol)
   );

   task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic boot(logic [7:0] o, logic [7:0] p);
      @(posedge clk);
      rstn <= 1'b0;
      nv_opt <= o;
      nv_prot <= p;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic wreg(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(logic [3:0] a, logic [7:0] e, string n);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(n, e, rdata);
   endtask

   task automatic mem(logic [15:0] a, logic [7:0] d);
      @(posedge clk);
      mwr <= 1'b1;
      maddr <= a;
      mdata <= d;
      @(posedge clk);
      mwr <= 1'b0;
      #1;
   endtask

   task automatic launch_at(logic [15:0] t, logic e);
      @(posedge clk);
      launch <= 1'b1;
      target <= t;
      @(posedge clk);
      launch <= 1'b0;
      #1 chk("accept", e, accept);
   endtask

   task automatic t_options;
      for (int s = 0; s < 4; s++) begin
         boot({2'b01, 4'hF, s[1:0]}, 8'hFE);
         chk("secure", s != 2, secure);
         chk("redirect", 1'b0, redir);
         rreg(`FSP_ADDR_OPT, {2'b01, 4'h0, s[1:0]}, "opt");
      end
      wreg(`FSP_ADDR_OPT, 8'h80);
      rreg(`FSP_ADDR_OPT, 8'h43, "opt write");
      wreg(`FSP_ADDR_CFG, 8'hFF);
      rreg(`FSP_ADDR_CFG, 8'hE0, "cfg");
      wreg(`FSP_ADDR_CFG, 8'h00);
      rreg(`FSP_ADDR_CFG, 8'h00, "cfg clear");
      $display("options and config test done");
   endtask

   // One key entry attempt from a secured start
   task automatic t_key(logic [7:0] o, logic s, logic bad, logic exp);
      boot(o, 8'hFE);
      chk("redirect", !o[6], redir);
      @(posedge clk);
      msec <= s;
      wreg(`FSP_ADDR_CFG, 8'h20);
      for (int i = 0; i < 8; i++) begin
         mem(16'hFFB0 + 16'(i), key[8*i +: 8] ^ {7'h00, bad && i == 7});
         if (s) chk("no start", 1'b0, cstart);
      end
      chk("secure before clear", 1'b1, secure);
      wreg(`FSP_ADDR_CFG, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk("secure", exp, secure);
      mem(16'hFFB3, 8'h00);
      chk("cmd start", 1'b1, cstart);
      mem(16'h8000, 8'h00);
      chk("cmd addr", 16'h8000, caddr);
      @(posedge clk);
      areq <= 1'b1;
      @(posedge clk);
      areq <= 1'b0;
      #1 chk("grant", !exp, grant);
      $display("key test done");
   endtask

   task automatic t_blank;
      boot(8'h00, 8'hFE);
      @(posedge clk);
      blank <= 1'b1;
      @(posedge clk);
      blank <= 1'b0;
      @(posedge clk);
      #1 chk("blank unlock", 1'b0, secure);
      $display("blank check test done");
   endtask

   task automatic t_protect;
      boot(8'h02, 8'h80);
      rreg(`FSP_ADDR_PROT, 8'h80, "prot load");
      wreg(`FSP_ADDR_PROT, 8'h20);
      rreg(`FSP_ADDR_PROT, 8'h80, "app write");
      @(posedge clk);
      dbg <= 1'b1;
      wreg(`FSP_ADDR_PROT, 8'hA0);
      rreg(`FSP_ADDR_PROT, 8'h80, "shrink");
      wreg(`FSP_ADDR_PROT, 8'h40);
      rreg(`FSP_ADDR_PROT, 8'h40, "grow");
      launch_at(16'h41FF, 1'b1);
      launch_at(16'h4200, 1'b0);
      chk("violation", 1'b1, viol);
      rreg(`FSP_ADDR_STAT, 8'h01, "status");
      wreg(`FSP_ADDR_STAT, 8'h01);
      rreg(`FSP_ADDR_STAT, 8'h00, "status clear");
      boot(8'h02, 8'h41);
      wreg(`FSP_ADDR_PROT, 8'h20);
      rreg(`FSP_ADDR_PROT, 8'h41, "disabled");
      launch_at(16'hFFFF, 1'b1);
      @(posedge clk);
      dbg <= 1'b0;
      $display("protection test done");
   endtask

   task automatic complete_run;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      t_options;
      t_key(8'h80, 1'b1, 1'b0, 1'b0);
      t_key(8'h00, 1'b1, 1'b0, 1'b1);
      t_key(8'h40, 1'b0, 1'b0, 1'b1);
      t_key(8'h80, 1'b1, 1'b1, 1'b1);
      t_blank;
      t_protect;
      complete_run;
   end

   // Tests need under a thousand cycles; this is ten times that
   initial begin
      #80000;
      miscompares++;
      complete_run;
   end
endmodule // testbench
